// *** hdl/bdsc_capture.sv ***
// Purpose: Host controller capturing the scanned BCD result
// Assumes: Converter pins arrive asynchronously; one AHB-Lite master
// Notes:   Latch, flag, counter and buffer are built in hardware
`timescale 1ns/1ns
`default_nettype none
module bdsc_capture
    import bdsc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Converter pins
    input  wire logic [3:0]  bcd_data_lines,
    input  wire logic        msd_select,
    input  wire logic        input_sign,
    input  wire logic        over_full_scale,
    input  wire logic        under_scale_flag,
    input  wire logic        digit_latch_n,
    input  wire logic        conv_busy,
    output var  logic        port_ctrl_out,
    // Result strobes
    output var  logic        result_valid,
    output var  logic        overrange_alert
);

    // ********************************************************
    // Pin synchronisation
    // ********************************************************
    logic [9:0] pins_sync;   // Synchronised converter pins
    logic       msd_s;       // Msd select, synchronised
    logic       strobe_s;    // Latch pulse, synchronised
    logic       busy_s;      // Busy, synchronised

    // All pin bits pass two flops together
    bdsc_sync #(.W(10)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .async_in({conv_busy, digit_latch_n, msd_select, input_sign,
                   under_scale_flag, over_full_scale, bcd_data_lines}),
        .sync_out(pins_sync)
    );

    // Low eight bits already sit in port byte order
    assign msd_s    = pins_sync[7];
    assign strobe_s = pins_sync[8];
    assign busy_s   = pins_sync[9];

    // ********************************************************
    // Edge detection of the latch pulse
    // ********************************************************
    logic strobe_d_reg;   // Previous synchronised pulse level
    logic fall_w;         // One-cycle falling edge
    logic [7:0] port_byte_w; // Byte as the port assembles it
    bdsc_state_t capt_state_reg;   // Capture state

    // Reading the fall keeps the port on the digit's mid point
    assign fall_w = strobe_d_reg & ~strobe_s;
    // Pack the port byte in its fixed layout
    assign port_byte_w = pins_sync[7:0];

    // ********************************************************
    // Bus decode
    // ********************************************************
    logic        ap_w;        // Address phase accepted
    logic        wr_ap_w;     // Write address phase
    logic        rd_ap_w;     // Read address phase
    logic        wr_dp_reg;   // Write data phase pending
    logic [7:0]  addr_reg;    // Latched address
    logic        rd_latch_w;  // Read of the latched port
    logic        wr_ctrl_w;   // Write data phase to control

    assign ap_w    = hsel & hready & htrans[1];
    assign wr_ap_w = ap_w & hwrite;
    assign rd_ap_w = ap_w & ~hwrite;
    assign rd_latch_w = rd_ap_w & (haddr == BDSC_LATCH_OFS);
    assign wr_ctrl_w  = wr_dp_reg & (addr_reg == BDSC_CTRL_OFS);

    // ********************************************************
    // Port latch and pending flag
    // ********************************************************
    logic [7:0] latch_reg;    // Port byte held between pulses
    logic       pend_reg;     // Pulse pending flag
    logic       pend_next;
    logic       miss_reg;     // Pulse arrived while capture not idle

    // Set wins over the read clear
    assign pend_next = fall_w ? 1'b1 : (rd_latch_w ? 1'b0 : pend_reg);

    // Latch on every falling edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Same level as the synchroniser at reset: no false fall
            strobe_d_reg <= 1'b0;
            latch_reg    <= 8'h00;
            pend_reg     <= 1'b0;
            miss_reg     <= 1'b0;
        end else begin
            strobe_d_reg <= strobe_s;
            if (fall_w) begin
                latch_reg <= port_byte_w;
            end
            pend_reg <= pend_next;
            // Unserviced digit lost
            if (fall_w && capt_state_reg != BDSC_IDLE) begin
                miss_reg <= 1'b1;
            end else if (wr_ctrl_w && hwdata[1]) begin
                miss_reg <= 1'b0;
            end
        end
    end

    // ********************************************************
    // Capture state machine and digit counter
    // ********************************************************
    bdsc_state_t capt_state_next;
    logic [2:0]  cnt_reg;          // Digit count cell
    logic [2:0]  cnt_next;
    logic [2:0]  idx_w;            // Buffer slot to write
    logic        new_scan_w;       // Msd digit, first of a new scan
    logic [7:0]  digit_buffer [0:4]; // Five stored digits
    logic        ovr_reg;          // Over-range seen this scan
    logic        done_w;           // Next count equals five

    // Msd select with a pulse starts the result
    assign new_scan_w = latch_reg[BDSC_MSD_BIT];
    // Counter restarts at zero for the msd digit
    assign idx_w   = new_scan_w ? 3'h0 : cnt_reg;
    // Increment and compare with five
    assign cnt_next = idx_w + 3'h1;
    assign done_w   = (cnt_next == BDSC_DIGITS);

    // Next state choice
    always_comb begin
        capt_state_next = capt_state_reg;
        case (capt_state_reg)
            BDSC_IDLE:  begin
                if (fall_w) begin
                    capt_state_next = BDSC_STORE;
                end
            end
            BDSC_STORE: begin
                // Fifth digit stored: pass through the done state
                if (done_w) begin
                    capt_state_next = BDSC_DONE;
                end else begin
                    capt_state_next = BDSC_IDLE;
                end
            end
            BDSC_DONE:  begin
                capt_state_next = BDSC_IDLE;
            end
            default:    begin
                capt_state_next = BDSC_IDLE;
            end
        endcase
    end

    // Store one digit per pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capt_state_reg <= BDSC_IDLE;
            cnt_reg        <= 3'h0;
            ovr_reg        <= 1'b0;
            result_valid   <= 1'b0;
            overrange_alert <= 1'b0;
        end else begin
            capt_state_reg <= capt_state_next;
            result_valid   <= 1'b0;
            overrange_alert <= 1'b0;
            if (capt_state_reg == BDSC_STORE && (new_scan_w ||
                cnt_reg < BDSC_DIGITS)) begin
                // Stray digits past five are dropped, not wrapped
                cnt_reg <= cnt_next;
                result_valid <= done_w;
                if (new_scan_w) begin
                    // Early over-range on the first digit
                    ovr_reg <= latch_reg[BDSC_OVR_BIT];
                    overrange_alert <= latch_reg[BDSC_OVR_BIT];
                end else if (latch_reg[BDSC_OVR_BIT]) begin
                    ovr_reg <= 1'b1;
                end
            end
        end
    end

    // Buffer write, no reset needed for data
    always_ff @(posedge hclk) begin
        if (capt_state_reg == BDSC_STORE && (new_scan_w ||
            cnt_reg < BDSC_DIGITS)) begin
            digit_buffer[idx_w] <= latch_reg;
        end
    end

    // ********************************************************
    // Run control
    // ********************************************************
    // Held high from reset so the converter runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_ctrl_out <= BDSC_RUN_RST;
        end else if (wr_ctrl_w) begin
            port_ctrl_out <= hwdata[0];
        end
    end

    // ********************************************************
    // Bus slave data phase
    // ********************************************************
    logic [31:0] rdata_w;   // Read mux
    logic [2:0]  slot_w;    // Buffer slot from address

    assign slot_w = 3'(haddr[5:2] - 4'h4);

    // Read mux from address phase
    always_comb begin
        rdata_w = 32'h0000_0000;
        if (haddr == BDSC_CTRL_OFS) begin
            rdata_w = {31'h0000_0000, port_ctrl_out};
        end else if (haddr == BDSC_STAT_OFS) begin
            rdata_w[BDSC_ST_VALID] = (cnt_reg == BDSC_DIGITS);
            rdata_w[BDSC_ST_PEND]  = pend_reg;
            rdata_w[BDSC_ST_OVR]   = ovr_reg;
            rdata_w[BDSC_ST_MISS]  = miss_reg;
            rdata_w[BDSC_ST_BUSY]  = busy_s;
            rdata_w[BDSC_ST_CNT +: 3] = cnt_reg;
        end else if (haddr == BDSC_LATCH_OFS) begin
            rdata_w = {24'h00_0000, latch_reg};
        end else if (haddr >= BDSC_DIG0_OFS && haddr <= BDSC_DIG4_OFS
                     && haddr[1:0] == 2'b00) begin
            rdata_w = {24'h00_0000, digit_buffer[slot_w]};
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_dp_reg <= 1'b0;
            addr_reg  <= 8'h00;
        end else begin
            wr_dp_reg <= wr_ap_w;
            if (ap_w) begin
                addr_reg <= haddr;
            end
            if (rd_ap_w) begin
                hrdata <= rdata_w;
            end
        end
    end

endmodule : bdsc_capture
`default_nettype wire

// *** hdl/bdsc_pkg.sv ***
// Purpose: Constants for the BCD digit scan capture controller
// Assumes: hclk at 100 MHz, converter pins asynchronous to hclk
// Notes:   Register offsets are byte addresses on AHB-Lite
package bdsc_pkg;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam logic [7:0] BDSC_CTRL_OFS   = 8'h00; // Run control
    localparam logic [7:0] BDSC_STAT_OFS   = 8'h04; // Status and count
    localparam logic [7:0] BDSC_LATCH_OFS  = 8'h08; // Latched port byte
    localparam logic [7:0] BDSC_DIG0_OFS   = 8'h10; // First buffer word
    localparam logic [7:0] BDSC_DIG4_OFS   = 8'h20; // Last buffer word

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic       BDSC_RUN_RST    = 1'b1;  // Run mode at reset

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int BDSC_OVR_BIT   = 4;   // Over-range in byte
    localparam int BDSC_UND_BIT   = 5;   // Under-range in byte
    localparam int BDSC_SIGN_BIT  = 6;   // Sign in byte
    localparam int BDSC_MSD_BIT   = 7;   // Msd select in byte
    localparam int BDSC_ST_VALID  = 0;   // Status: result valid
    localparam int BDSC_ST_PEND   = 1;   // Status: pulse pending
    localparam int BDSC_ST_OVR    = 2;   // Status: over-range seen
    localparam int BDSC_ST_MISS   = 3;   // Status: digit overrun
    localparam int BDSC_ST_BUSY   = 4;   // Status: converter busy
    localparam int BDSC_ST_CNT    = 8;   // Status: digit count lsb

    // ********************************************************
    // Scan geometry and timing
    // ********************************************************
    localparam logic [2:0] BDSC_DIGITS     = 3'h5;  // Digits per scan
    localparam int BDSC_CONV_HZ      = 100000;      // Converter clock
    localparam int BDSC_PULSE_CLKS   = 200;         // Pulse spacing
    localparam int BDSC_HCLK_HZ      = 100000000;   // Bus clock
    // Service window per digit in microseconds
    localparam int BDSC_SERVICE_US   =
        (BDSC_PULSE_CLKS * 1000000) / BDSC_CONV_HZ;
    // Same window in hclk cycles, rounded down
    localparam int BDSC_SERVICE_CYC  =
        BDSC_SERVICE_US * (BDSC_HCLK_HZ / 1000000);

    // ********************************************************
    // Capture state machine
    // ********************************************************
    typedef enum logic [2:0] {
        BDSC_IDLE  = 3'b001,  // Waiting for a pulse
        BDSC_STORE = 3'b010,  // Writing a digit to the buffer
        BDSC_DONE  = 3'b100   // Scan complete
    } bdsc_state_t;

endpackage : bdsc_pkg

// *** hdl/bdsc_sync.sv ***
// Purpose: Two flip-flop synchroniser for a bus of converter pins
// Assumes: Inputs are asynchronous to hclk
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ns
`default_nettype none
module bdsc_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;   // First stage, read only by second

    // ********************************************************
    // Double register
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : bdsc_sync
`default_nettype wire

// *** verification/bdsc_capture_props.sv ***
// Purpose: Port-level checks of the capture controller
// Assumes: Single clock domain, bound to bdsc_capture
// Notes:   Pulse count is rebuilt from the pins, not the design
`timescale 1ns/1ns
`default_nettype none
module bdsc_capture_props
    import bdsc_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        msd_select,
    input wire logic        over_full_scale,
    input wire logic        digit_latch_n,
    input wire logic        port_ctrl_out,
    input wire logic        result_valid,
    input wire logic        overrange_alert
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ********************************************************
    // Helper logic
    // ********************************************************
    logic [2:0] seen_cnt; // Pulses since the last msd pulse
    logic       pin_q;    // Pulse pin one cycle ago
    wire acc    = hsel & hready & htrans[1];
    wire fall   = pin_q & ~digit_latch_n;
    wire wr_ctl = acc & hwrite & (haddr == BDSC_CTRL_OFS);
    wire rd_gap = acc & ~hwrite & (haddr == 8'h0C);
    // Counts pulses the way the host software would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_cnt <= 3'h0;
            pin_q    <= 1'b1;
        end else begin
            pin_q <= digit_latch_n;
            if (fall && msd_select) begin
                seen_cnt <= 3'h1;
            end else if (fall && seen_cnt < 3'h5) begin
                seen_cnt <= seen_cnt + 3'h1;
            end
        end
    end
    // ********************************************************
    // Properties
    // ********************************************************
    sequence s_fifth;
        fall && !msd_select && seen_cnt == 3'h4;
    endsequence
    sequence s_msd_over;
        fall && msd_select && over_full_scale;
    endsequence
    property p_okay;
        hresp == 1'b0 && hreadyout == 1'b1;
    endproperty
    property p_fifth;
        s_fifth |-> ##[2:7] result_valid;
    endproperty
    property p_valid_cnt;
        result_valid |-> seen_cnt == 3'h5;
    endproperty
    property p_valid_one;
        result_valid |=> !result_valid;
    endproperty
    property p_alert;
        s_msd_over |-> ##[2:7] overrange_alert;
    endproperty
    property p_alert_msd;
        overrange_alert |-> seen_cnt == 3'h1;
    endproperty
    property p_ctrl_wr;
        wr_ctl |-> ##2 port_ctrl_out == $past(hwdata[0]);
    endproperty
    property p_ctrl_hold;
        $changed(port_ctrl_out) |-> $past(wr_ctl, 2);
    endproperty
    property p_unmapped;
        rd_gap |=> hrdata == 32'h0000_0000;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus not ready or not okay");
    a_fifth: assert property (p_fifth)
        else $error("no result strobe after fifth pulse");
    a_valid_cnt: assert property (p_valid_cnt)
        else $error("result strobe without five pulses");
    a_valid_one: assert property (p_valid_one)
        else $error("result strobe longer than one cycle");
    a_alert: assert property (p_alert)
        else $error("over-range on msd not flagged");
    a_alert_msd: assert property (p_alert_msd)
        else $error("over-range alert off the msd digit");
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("run output not set by write");
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("run output moved without write");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule : bdsc_capture_props
bind bdsc_capture bdsc_capture_props chk_u (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .msd_select, .over_full_scale, .digit_latch_n,
    .port_ctrl_out, .result_valid, .overrange_alert);
`default_nettype wire

// *** verification/bdsc_conv_model.sv ***
// Purpose: Behavioural converter that scans one result per request
// Assumes: One hclk stands for one converter clock
// Notes:   Pulse held low 4 hclk so the synchroniser catches it
`timescale 1ns/1ns
`default_nettype none
module bdsc_conv_model (
    input  wire logic        hclk,
    input  wire logic        run,
    input  wire logic        go,
    input  wire logic        pos,
    input  wire logic [15:0] count,
    output var  logic [3:0]  bcd,
    output var  logic        msd,
    output var  logic        sgn,
    output var  logic        ovr,
    output var  logic        und,
    output var  logic        strobe_n,
    output var  logic        busy
);
    int         d;     // Digit index, msd first
    logic [3:0] v;     // Digit now on the lines
    // ********************************************************
    // One conversion, then one scan with latch pulses
    // ********************************************************
    initial begin
        {bcd, msd, sgn, ovr, und, busy} = '0;
        strobe_n = 1'b1;
        forever begin
            @(posedge hclk);
            // Held in auto-zero while run is low
            if (run && go) begin
                busy <= 1'b1;
                repeat (30) @(posedge hclk);
                busy <= 1'b0;
                for (d = 0; d < 5; d++) begin
                    v = 4'((count / (10 ** (4 - d))) % 10);
                    msd <= (d == 0); // One select at a time
                    bcd <= v;
                    sgn <= pos;
                    ovr <= (count > 16'h4E20);
                    und <= (count <= 16'h0708);
                    repeat (98) @(posedge hclk);
                    strobe_n <= 1'b0; // Mid-digit
                    repeat (4) @(posedge hclk);
                    strobe_n <= 1'b1;
                    repeat (98) @(posedge hclk);
                end
                msd <= 1'b0;
                bcd <= ~v; // Lines released: inverse, never stale
            end
        end
    end
endmodule : bdsc_conv_model
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the capture controller
// Assumes: One AHB-Lite master, converter model on the pins
// Notes:   Readings cover mid scale, under and over range
`timescale 1ns/1ns
`default_nettype none
module tb;
    import bdsc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, go, pos, seen_alert;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rv;
    logic        hreadyout, hresp, port_ctrl_out, result_valid, alert;
    logic [3:0]  bcd;
    logic        msd, sgn, ovr, und, strobe_n, busy;
    logic [15:0] count;
    int          n_mismatch, cmp_count;
    // 12345, 1500, 25000 counts
    logic [15:0] vals [3] = '{16'h3039, 16'h05DC, 16'h61A8};
    bdsc_capture dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .bcd_data_lines(bcd), .msd_select(msd),
        .input_sign(sgn), .over_full_scale(ovr),
        .under_scale_flag(und), .digit_latch_n(strobe_n),
        .conv_busy(busy), .port_ctrl_out, .result_valid,
        .overrange_alert(alert));
    bdsc_conv_model conv_u (.hclk, .run(port_ctrl_out), .go, .pos,
        .count, .bcd, .msd, .sgn, .ovr, .und, .strobe_n, .busy);
    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask : check
    // Bounded wait for hready; a hang ends the run
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rv = hrdata;
    endtask : bus
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(n, rv, e);
    endtask : rchk
    // Byte the port should hold for digit k of a reading
    function automatic logic [31:0] exp_byte(input logic [15:0] c,
                                             input logic p, input int k);
        logic [3:0] v;
        v = 4'((c / (10 ** (4 - k))) % 10);
        return {24'h0, k == 0, p, c <= 16'h0708, c > 16'h4E20, v};
    endfunction : exp_byte
    // Request one conversion and wait for the result strobe
    task automatic convert(input logic [15:0] c, input logic p);
        int i;
        count <= c;
        pos   <= p;
        go    <= 1'b1;
        @(posedge hclk);
        go    <= 1'b0;
        repeat (8) @(posedge hclk);
        bus(1'b0, BDSC_STAT_OFS, 32'h0000_0000);
        check("busy", {31'h0, rv[4]}, 32'h0000_0001);
        for (i = 0; i < 1500 && result_valid !== 1'b1; i++) begin
            @(posedge hclk);
        end
        if (i == 1500) begin
            n_mismatch++;
            give_verdict();
        end
        repeat (120) @(posedge hclk);
    endtask : convert
    // ********************************************************
    // Clock, alert watch and main sequence
    // ********************************************************
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (alert === 1'b1) begin
            seen_alert <= 1'b1;
        end
    end
    initial begin
        {hsel, hwrite, go, pos, seen_alert, hresetn} = '0;
        {haddr, htrans, hwdata, count} = '0;
        hsize = 3'b010;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("ctrl", BDSC_CTRL_OFS, 32'h0000_0001);
        rchk("stat", BDSC_STAT_OFS, 32'h0000_0000);
        rchk("gap", 8'h0C, 32'h0000_0000);
        // Each scan restarts the count on the msd pulse
        for (int t = 0; t < 3; t++) begin
            convert(vals[t], t[0]);
            rchk("stat", BDSC_STAT_OFS, {21'h0, 3'h5, 5'h0,
                vals[t] > 16'h4E20, 2'b11});
            for (int k = 0; k < 5; k++) begin
                rchk("digit", 8'(BDSC_DIG0_OFS + 4 * k),
                     exp_byte(vals[t], t[0], k));
            end
            rchk("latch", BDSC_LATCH_OFS, exp_byte(vals[t], t[0], 4));
            bus(1'b0, BDSC_STAT_OFS, 32'h0000_0000);
            check("pend", {31'h0, rv[1]}, 32'h0000_0000);
        end
        check("alert", {31'h0, seen_alert}, 32'h0000_0001);
        // Hold: run low must stop any new conversion
        bus(1'b1, BDSC_CTRL_OFS, 32'h0000_0000);
        @(posedge hclk);
        check("hold", {31'h0, port_ctrl_out}, 32'h0000_0000);
        convert_hold: begin
            go <= 1'b1;
            @(posedge hclk);
            go <= 1'b0;
            // Look inside the window where a started run shows busy
            repeat (10) @(posedge hclk);
        end
        rchk("held", BDSC_STAT_OFS, {21'h0, 3'h5, 8'h05});
        bus(1'b1, BDSC_CTRL_OFS, 32'h0000_0001);
        rchk("run", BDSC_CTRL_OFS, 32'h0000_0001);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
